// ==== rtl/ebpc_pkg.sv ====
// package for the external bus pin control block
// assumes a single 200 MHz machine clock domain
package ebpc_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_AUTO_WAIT = 10'h0a5;
  localparam logic [9:0] IDX_ADDR_PIN  = 10'h0a6;
  localparam logic [9:0] IDX_SIG_SEL   = 10'h0a7;
  localparam int         AXI_AW        = 12;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IO_WAIT_LSB = 6;
  localparam int UP_WAIT_LSB = 4;
  localparam int LO_WAIT_LSB = 0;
  localparam int LO_SIZE_BIT = 6;
  localparam int WR_EN_BIT   = 5;
  localparam int UP_SIZE_BIT = 4;
  localparam int IO_SIZE_BIT = 3;
  localparam int HOLD_BIT    = 2;
  localparam int RDY_BIT     = 1;
  localparam int CLK_BIT     = 0;
  // ----------------------------------------------------------------
  // reset values and read-back
  // ----------------------------------------------------------------
  localparam logic [7:0]  AUTO_WAIT_RST = 8'h30;
  localparam logic [7:0]  ADDR_PIN_RST  = 8'h00;
  localparam logic [7:0]  SIG_SEL_RST   = 8'h00;
  localparam logic [31:0] READ_ONES     = 32'h0000_00ff;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ----------------------------------------------------------------
  // address areas
  // ----------------------------------------------------------------
  localparam logic [23:0] IO_FIRST = 24'h00_00c0;
  localparam logic [23:0] IO_LAST  = 24'h00_00ff;
  localparam logic [23:0] LO_FIRST = 24'h00_2000;
  localparam logic [23:0] LO_LAST  = 24'h7f_ffff;
  localparam logic [23:0] UP_FIRST = 24'h80_0000;
  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BOOT_S0  = 4'b0001,
    BOOT_S1  = 4'b0010,
    BOOT_LD  = 4'b0100,
    BOOT_RUN = 4'b1000
  } boot_t;
endpackage

// ==== rtl/area_cfg_if.sv ====
// carrier between the register bank and the area decoder
// assumes both ends on mclk
`timescale 1ns/1ps
`default_nettype none
interface area_cfg_if;
  logic [1:0]  io_wait;
  logic [1:0]  up_wait;
  logic [1:0]  lo_wait;
  logic        io_size;
  logic        up_size;
  logic        lo_size;
  logic        bus16;
  logic [23:0] addr;
  logic        req;
  logic [1:0]  wait_cnt;
  logic        narrow;
  logic        ext_area;
  modport cfg (output io_wait, up_wait, lo_wait, io_size, up_size, lo_size,
               output bus16, addr, req, input wait_cnt, narrow, ext_area);
  modport dec (input io_wait, up_wait, lo_wait, io_size, up_size, lo_size,
               input bus16, addr, req, output wait_cnt, narrow, ext_area);
endinterface
`default_nettype wire

// ==== rtl/area_wait_decode.sv ====
// area decoder: wait count and bus width for one access address
// assumes config fields are stable flops on mclk
`timescale 1ns/1ps
`default_nettype none
module area_wait_decode (
  input  wire logic mclk,
  input  wire logic nrst,
  area_cfg_if.dec   cfg
);
  logic in_io;
  logic in_lo;
  logic in_up;

  assign in_io = cfg.addr >= ebpc_pkg::IO_FIRST && cfg.addr <= ebpc_pkg::IO_LAST;
  assign in_lo = cfg.addr >= ebpc_pkg::LO_FIRST && cfg.addr <= ebpc_pkg::LO_LAST;
  assign in_up = cfg.addr >= ebpc_pkg::UP_FIRST;

  // ----------------------------------------------------------------
  // lookup, result held until the next request
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg.wait_cnt <= 2'h0;
      cfg.narrow   <= 1'b0;
      cfg.ext_area <= 1'b0;
    end else if (cfg.req) begin
      cfg.ext_area <= in_io | in_lo | in_up;
      if (in_io) begin
        cfg.wait_cnt <= cfg.io_wait; // R1
        cfg.narrow   <= ~cfg.bus16 | cfg.io_size; // R9
      end else if (in_up) begin
        cfg.wait_cnt <= cfg.up_wait; // R2
        cfg.narrow   <= ~cfg.bus16 | cfg.up_size; // R8
      end else if (in_lo) begin
        cfg.wait_cnt <= cfg.lo_wait; // R3
        cfg.narrow   <= ~cfg.bus16 | cfg.lo_size; // R7
      end else begin
        // internal space: no automatic wait, width follows the bus mode
        cfg.wait_cnt <= 2'h0;
        cfg.narrow   <= ~cfg.bus16;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ext_bus_pin_ctrl.sv ====
// external bus pin control: three write-only byte registers on AXI4-Lite
// assumes straps and pins are asynchronous; acc_* and hold_grant are on mclk
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: io area c0..ff gets 0 to 3 auto waits from its two-bit field.
// R2: upper area 800000..ffffff gets 0 to 3 waits, field resets to 11.
// R3: lower area 2000..7fffff gets 0 to 3 waits, field resets to 00.
// R4: each upper address enable bit turns pin a23..a16 into address output.
// R5: single-chip mode blocks pin register writes and forces all pins to ports.
// R6: pin registers are write-only, read all ones, address enables reset to zero.
// R7: lower area is 16-bit when its size bit is 0 on a 16-bit bus, else 8-bit.
// R8: upper size bit resets to 1 in vector modes 0 and 2, else 0.
// R9: io area is 16-bit when its size bit is 0 on a 16-bit bus, else 8-bit.
// R10: write strobe enable drives both strobes in 16-bit mode, one in 8-bit.
// R11: in 8-bit mode the high strobe pin stays a port.
// R12: hold enable passes hold request in and drives hold acknowledge out.
// R13: ready enable honours external ready, otherwise ready is ignored.
// R14: clock enable drives the bus clock on the clock pin.
// R15: outside devices tolerate programmed waits; software programs first.
// R16: writes reach pin functions next cycle; contents change only by write, reset or the strap load of the upper size bit.
module ext_bus_pin_ctrl (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        single_chip_pin,
  input  wire logic        bus16_pin,
  input  wire logic [1:0]  vector_mode_pin,
  input  wire logic        hold_request_in,
  input  wire logic        ext_ready_pin,
  input  wire logic        hold_grant,
  input  wire logic [23:0] acc_addr,
  input  wire logic        acc_req,
  output logic [1:0]       acc_wait,
  output logic             acc_narrow,
  output logic             acc_ext_area,
  output logic [7:0]       addr_pin_enable,
  output logic             wrl_strobe_enable,
  output logic             wrh_strobe_enable,
  output logic             hold_pins_enable,
  output logic             hold_request_out,
  output logic             hold_ack_out_n,
  output logic             ready_pin_enable,
  output logic             ext_ready_out,
  output logic             bus_clk_out,
  output logic             bus_clk_oe
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0]          sync1_reg;
  logic [5:0]          sync2_reg;
  logic                single_chip;
  logic                bus16;
  logic [1:0]          vec_mode;
  logic                hold_req_s;
  logic                rdy_s;
  logic                ext_mode;
  ebpc_pkg::boot_t     boot_reg;
  logic [7:0]          auto_wait_reg;
  logic [7:0]          addr_pin_reg;
  logic [7:0]          sig_sel_reg;
  logic [9:0]          aw_idx_reg;
  logic [7:0]          wbyte_reg;
  logic                wlane_reg;
  logic                wr_commit;
  logic                aw_hit;
  logic                ar_hit;
  logic [9:0]          ar_idx;
  logic                clk_toggle_reg;
  area_cfg_if          cfg_bus ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // straps are sampled continuously; changing them at run time is legal
  // but only the upper size bit is derived from the vector mode, once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {single_chip_pin, bus16_pin, vector_mode_pin,
                    hold_request_in, ext_ready_pin};
      sync2_reg <= sync1_reg;
    end
  end

  assign single_chip = sync2_reg[5];
  assign bus16       = sync2_reg[4];
  assign vec_mode    = sync2_reg[3:2];
  assign hold_req_s  = sync2_reg[1];
  assign rdy_s       = sync2_reg[0];
  assign ext_mode    = ~single_chip;

  // ----------------------------------------------------------------
  // strap capture sequence
  // ----------------------------------------------------------------
  // two edges fill the synchroniser, the third loads the strap value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      boot_reg <= ebpc_pkg::BOOT_S0;
    end else begin
      case (boot_reg)
        ebpc_pkg::BOOT_S0:  boot_reg <= ebpc_pkg::BOOT_S1;
        ebpc_pkg::BOOT_S1:  boot_reg <= ebpc_pkg::BOOT_LD;
        ebpc_pkg::BOOT_LD:  boot_reg <= ebpc_pkg::BOOT_RUN;
        ebpc_pkg::BOOT_RUN: boot_reg <= ebpc_pkg::BOOT_RUN;
        default:            boot_reg <= ebpc_pkg::BOOT_S0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // ready low means the beat is held; commit once both are held
  assign wr_commit = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign aw_hit    = aw_idx_reg == ebpc_pkg::IDX_AUTO_WAIT
                   || aw_idx_reg == ebpc_pkg::IDX_ADDR_PIN
                   || aw_idx_reg == ebpc_pkg::IDX_SIG_SEL;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      aw_idx_reg    <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_idx_reg    <= s_axi_awaddr[11:2];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_wready <= 1'b1;
      wbyte_reg    <= 8'h00;
      wlane_reg    <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wbyte_reg    <= s_axi_wdata[7:0];
      wlane_reg    <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ebpc_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_hit ? ebpc_pkg::RESP_OKAY : ebpc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // contents change only by reset, a committed write with byte lane 0 set, or the strap load of the upper size bit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      auto_wait_reg <= ebpc_pkg::AUTO_WAIT_RST; // R2 R3
    end else if (wr_commit && wlane_reg && aw_idx_reg == ebpc_pkg::IDX_AUTO_WAIT) begin
      auto_wait_reg <= wbyte_reg; // R16
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_pin_reg <= ebpc_pkg::ADDR_PIN_RST; // R6
    end else if (wr_commit && wlane_reg && ext_mode
                 && aw_idx_reg == ebpc_pkg::IDX_ADDR_PIN) begin
      addr_pin_reg <= wbyte_reg; // R5
    end
  end

  // a software write in the strap-load cycle wins over the strap
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sig_sel_reg <= ebpc_pkg::SIG_SEL_RST;
    end else if (wr_commit && wlane_reg && ext_mode
                 && aw_idx_reg == ebpc_pkg::IDX_SIG_SEL) begin
      sig_sel_reg <= wbyte_reg; // R5
    end else if (boot_reg == ebpc_pkg::BOOT_LD) begin
      sig_sel_reg[ebpc_pkg::UP_SIZE_BIT] <= ~vec_mode[0]; // R8
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // every register is write-only, so reads never expose contents
  assign ar_idx = s_axi_araddr[11:2];
  assign ar_hit = ar_idx == ebpc_pkg::IDX_AUTO_WAIT
               || ar_idx == ebpc_pkg::IDX_ADDR_PIN
               || ar_idx == ebpc_pkg::IDX_SIG_SEL;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ebpc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= ar_hit ? ebpc_pkg::READ_ONES : 32'h0000_0000; // R6
      s_axi_rresp   <= ar_hit ? ebpc_pkg::RESP_OKAY : ebpc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // area decoder
  // ----------------------------------------------------------------
  assign cfg_bus.io_wait = auto_wait_reg[ebpc_pkg::IO_WAIT_LSB +: 2];
  assign cfg_bus.up_wait = auto_wait_reg[ebpc_pkg::UP_WAIT_LSB +: 2];
  assign cfg_bus.lo_wait = auto_wait_reg[ebpc_pkg::LO_WAIT_LSB +: 2];
  assign cfg_bus.io_size = sig_sel_reg[ebpc_pkg::IO_SIZE_BIT];
  assign cfg_bus.up_size = sig_sel_reg[ebpc_pkg::UP_SIZE_BIT];
  assign cfg_bus.lo_size = sig_sel_reg[ebpc_pkg::LO_SIZE_BIT];
  assign cfg_bus.bus16   = bus16;
  assign cfg_bus.addr    = acc_addr;
  assign cfg_bus.req     = acc_req;
  assign acc_wait        = cfg_bus.wait_cnt;
  assign acc_narrow      = cfg_bus.narrow;
  assign acc_ext_area    = cfg_bus.ext_area;

  area_wait_decode u_dec (
    .mclk (mclk),
    .nrst (nrst),
    .cfg  (cfg_bus.dec)
  );

  // ----------------------------------------------------------------
  // pin function selects
  // ----------------------------------------------------------------
  // one flop stage after the register: new settings act next cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_pin_enable <= 8'h00;
    end else begin
      addr_pin_enable <= ext_mode ? addr_pin_reg : 8'h00; // R4 R5 R16
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrl_strobe_enable <= 1'b0;
      wrh_strobe_enable <= 1'b0;
    end else begin
      wrl_strobe_enable <= ext_mode & sig_sel_reg[ebpc_pkg::WR_EN_BIT]; // R10
      wrh_strobe_enable <= ext_mode & bus16
                         & sig_sel_reg[ebpc_pkg::WR_EN_BIT]; // R11
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_pins_enable <= 1'b0;
      hold_request_out <= 1'b0;
      hold_ack_out_n   <= 1'b1;
    end else begin
      hold_pins_enable <= ext_mode & sig_sel_reg[ebpc_pkg::HOLD_BIT]; // R12
      hold_request_out <= ext_mode & sig_sel_reg[ebpc_pkg::HOLD_BIT] & hold_req_s;
      hold_ack_out_n   <= ~(ext_mode & sig_sel_reg[ebpc_pkg::HOLD_BIT] & hold_grant);
    end
  end

  // with ready disabled the sequencer sees a permanent ready
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ready_pin_enable <= 1'b0;
      ext_ready_out    <= 1'b1;
    end else begin
      ready_pin_enable <= ext_mode & sig_sel_reg[ebpc_pkg::RDY_BIT]; // R13
      ext_ready_out    <= (ext_mode & sig_sel_reg[ebpc_pkg::RDY_BIT]) ? rdy_s : 1'b1;
    end
  end

  // bus clock is mclk divided by two; parked low while disabled
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_toggle_reg <= 1'b0;
      bus_clk_out    <= 1'b0;
      bus_clk_oe     <= 1'b0;
    end else begin
      clk_toggle_reg <= ~clk_toggle_reg;
      bus_clk_out    <= ext_mode & sig_sel_reg[ebpc_pkg::CLK_BIT] & clk_toggle_reg; // R14
      bus_clk_oe     <= ext_mode & sig_sel_reg[ebpc_pkg::CLK_BIT];
    end
  end
endmodule
`default_nettype wire

// ==== dv/ebpc_partner.sv ====
// far-side model: memories and peripherals on the expanded bus
// assumes the bench commands hold requests and slow answers
`timescale 1ns/1ps
`default_nettype none
module ebpc_partner (
  input  wire logic mclk,
  input  wire logic want_hold,
  input  wire logic slow,
  output logic      hold_request_in,
  output logic      ext_ready_pin
);
  // a slow device keeps ready low for as long as it needs
  always_ff @(posedge mclk) begin
    hold_request_in <= want_hold;
    ext_ready_pin   <= !slow;
  end
endmodule
`default_nettype wire

// ==== dv/ext_bus_pin_ctrl_props.sv ====
// checker for the external bus pin control block
// assumes a bind to ext_bus_pin_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ext_bus_pin_ctrl_props (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        single_chip_pin,
  input wire logic        bus16_pin,
  input wire logic [23:0] acc_addr,
  input wire logic        acc_req,
  input wire logic [1:0]  acc_wait,
  input wire logic        acc_narrow,
  input wire logic        acc_ext_area,
  input wire logic [7:0]  addr_pin_enable,
  input wire logic        wrl_strobe_enable,
  input wire logic        wrh_strobe_enable,
  input wire logic        hold_pins_enable,
  input wire logic        hold_ack_out_n,
  input wire logic        ready_pin_enable,
  input wire logic        ext_ready_out,
  input wire logic        bus_clk_out,
  input wire logic        bus_clk_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic mapped;
  assign mapped = s_axi_araddr[11:2] inside {ebpc_pkg::IDX_AUTO_WAIT, ebpc_pkg::IDX_ADDR_PIN,
                                             ebpc_pkg::IDX_SIG_SEL};
  // straps pass two sync flops and an output flop, so four samples
  sequence held(sig);
    sig [*4];
  endsequence
  sequence rd_take(ok);
    s_axi_arvalid && s_axi_arready && ok;
  endsequence
  a_rd_ones: assert property (rd_take(mapped) |=>
    s_axi_rvalid && s_axi_rdata == 32'h0000_00ff)
    else $error("mapped read not all ones");
  a_single_chip: assert property (held(single_chip_pin) |-> addr_pin_enable == 8'h00 &&
    !(wrl_strobe_enable || wrh_strobe_enable || hold_pins_enable ||
    ready_pin_enable || bus_clk_oe))
    else $error("pin function active in single-chip mode");
  a_wrh_narrow: assert property (held(!bus16_pin) |-> !wrh_strobe_enable)
    else $error("high strobe enabled on 8-bit bus");
  a_narrow_bus: assert property (held(!bus16_pin) ##0 acc_req |=> acc_narrow)
    else $error("wide access on 8-bit bus");
  a_acc_io: assert property (acc_req && acc_addr inside {[24'h00_00c0:24'h00_00ff]}
    |=> acc_ext_area)
    else $error("io area not decoded");
  a_acc_low: assert property (acc_req && acc_addr inside {[24'h00_2000:24'h7f_ffff]}
    |=> acc_ext_area)
    else $error("lower area not decoded");
  a_acc_up: assert property (acc_req && acc_addr >= 24'h80_0000 |=> acc_ext_area)
    else $error("upper area not decoded");
  a_acc_internal: assert property (acc_req && acc_addr < 24'h00_00c0 |=>
    !acc_ext_area && acc_wait == 2'h0)
    else $error("internal address given waits");
  a_hold_idle: assert property ((!hold_pins_enable) [*2] |-> hold_ack_out_n)
    else $error("hold acknowledge while hold pins are ports");
  a_ready_idle: assert property ((!ready_pin_enable) [*2] |-> ext_ready_out)
    else $error("external ready not ignored");
  a_clk_idle: assert property ((!bus_clk_oe) [*2] |-> !bus_clk_out)
    else $error("bus clock runs while disabled");
  a_clk_toggle: assert property (held(bus_clk_oe) |-> bus_clk_out != $past(bus_clk_out))
    else $error("bus clock stuck while enabled");
endmodule
bind ext_bus_pin_ctrl ext_bus_pin_ctrl_props props (.mclk, .nrst, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .single_chip_pin, .bus16_pin, .acc_addr, .acc_req,
  .acc_wait, .acc_narrow, .acc_ext_area, .addr_pin_enable, .wrl_strobe_enable, .wrh_strobe_enable,
  .hold_pins_enable, .hold_ack_out_n, .ready_pin_enable, .ext_ready_out, .bus_clk_out, .bus_clk_oe);
`default_nettype wire

// ==== dv/external_bus_pin_control_bench.sv ====
// self-checking bench for ext_bus_pin_ctrl against a register model
// assumes the design package and the far-side model are compiled first
`timescale 1ns/1ps
`default_nettype none
module external_bus_pin_control_bench;
  logic        mclk = '0, nrst = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0, single_chip_pin = '0, bus16_pin = '0;
  logic        hold_grant = '0, acc_req = '0, want_hold = '0, slow = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, r;
  logic [3:0]  s_axi_wstrb = '0;
  logic [1:0]  vector_mode_pin = '0, s_axi_bresp, s_axi_rresp, acc_wait;
  logic [23:0] acc_addr = '0;
  logic [7:0]  addr_pin_enable, aw_m, ap_m, ss_m;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        hold_request_in, ext_ready_pin, acc_narrow, acc_ext_area, wrl_strobe_enable;
  logic        wrh_strobe_enable, hold_pins_enable, hold_request_out, hold_ack_out_n;
  logic        ready_pin_enable, ext_ready_out, bus_clk_out, bus_clk_oe;
  int          failures = 0, compares = 0;
  always #2.5 mclk = ~mclk;
  ext_bus_pin_ctrl DUT (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .single_chip_pin, .bus16_pin, .vector_mode_pin, .hold_request_in,
    .ext_ready_pin, .hold_grant, .acc_addr, .acc_req, .acc_wait, .acc_narrow, .acc_ext_area,
    .addr_pin_enable, .wrl_strobe_enable, .wrh_strobe_enable, .hold_pins_enable,
    .hold_request_out, .hold_ack_out_n, .ready_pin_enable, .ext_ready_out, .bus_clk_out,
    .bus_clk_oe);
  ebpc_partner far (.mclk, .want_hold, .slow, .hold_request_in, .ext_ready_pin);
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // write and read hold every request until its own handshake edge
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
                        input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 64) failures++;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 64) failures++;
    check("rdata", s_axi_rdata, ed);
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  // ----
  // model
  // ----
  function automatic logic [3:0] acc_exp(input logic [23:0] a);
    logic n;
    n = !bus16_pin;
    if (a >= 24'h00_00c0 && a <= 24'h00_00ff) return {aw_m[7:6], n | ss_m[3], 1'b1};
    if (a >= 24'h00_2000 && a <= 24'h7f_ffff) return {aw_m[1:0], n | ss_m[6], 1'b1};
    if (a >= 24'h80_0000) return {aw_m[5:4], n | ss_m[4], 1'b1};
    return {2'h0, n, 1'b0};
  endfunction
  task automatic acc_all;
    logic [23:0] q[$];
    logic [31:0] got;
    q = {24'h00_00c0 | 24'(r[5:0]), 24'h00_00bf, 24'h00_1fff, 24'h00_2000, 24'h7f_ffff,
         24'h80_0000, r[23:0]};
    foreach (q[k]) begin
      @(posedge mclk);
      acc_addr <= q[k];
      acc_req <= 1'b1;
      @(posedge mclk);
      acc_req <= 1'b0;
      @(negedge mclk);
      got = 32'({acc_wait, acc_narrow, acc_ext_area});
      check("acc", got, 32'(acc_exp(q[k])));
    end
  endtask
  task automatic pins_chk;
    logic s, w, h, y;
    logic [31:0] got, ex;
    @(negedge mclk);
    s = !single_chip_pin;
    w = s & ss_m[5];
    h = s & ss_m[2];
    y = s & ss_m[1];
    got = 32'({addr_pin_enable, wrl_strobe_enable, wrh_strobe_enable, hold_pins_enable,
               hold_request_out, hold_ack_out_n, ready_pin_enable, ext_ready_out, bus_clk_oe});
    ex = 32'({s ? ap_m : 8'h00, w, w & bus16_pin, h, h & want_hold, !(h & hold_grant), y,
              !y | !slow, s & ss_m[0]});
    check("pins", got, ex);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    r = 32'h0776_a436;
    for (int v = 0; v < 4; v++) begin
      @(posedge mclk);
      vector_mode_pin <= 2'(v);
      bus16_pin <= (v != 3);
      nrst <= 1'b0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      aw_m = 8'h30;
      ap_m = 8'h00;
      ss_m = v[0] ? 8'h00 : 8'h10;
      pins_chk;
      acc_all;
      for (int i = 0; i < 3; i++) begin
        r = lfsr(r);
        axi_wr(12'h294, r[7:0], 4'h1, 2'h0);
        aw_m = r[7:0];
        r = lfsr(r);
        axi_wr(12'h298, r[7:0], 4'hf, 2'h0);
        ap_m = r[7:0];
        r = lfsr(r);
        axi_wr(12'h29c, r[7:0], 4'h1, 2'h0);
        ss_m = r[7:0];
        {want_hold, hold_grant, slow} <= r[10:8];
        repeat (5) @(posedge mclk);
        pins_chk;
        acc_all;
      end
    end
    for (int k = 0; k < 4; k++) begin
      axi_rd(12'h294 + 12'(4 * k), k < 3 ? 32'h0000_00ff : 32'h0000_0000, k < 3 ? 2'h0 : 2'h2);
    end
    // single-chip mode drops pin register writes but still answers them
    single_chip_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    pins_chk;
    axi_wr(12'h298, 8'hff, 4'h1, 2'h0);
    axi_wr(12'h29c, 8'h7f, 4'h1, 2'h0);
    axi_rd(12'h29c, 32'h0000_00ff, 2'h0);
    pins_chk;
    @(posedge mclk);
    single_chip_pin <= 1'b0;
    repeat (5) @(posedge mclk);
    pins_chk;
    axi_wr(12'h294, 8'h00, 4'h0, 2'h0);
    axi_wr(12'h000, 8'hff, 4'h1, 2'h2);
    acc_all;
    summarize;
  end
  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    summarize;
  end
endmodule
`default_nettype wire
